// [include/gsr_pkg.sv]
// Shared constants and types for the status-reporting block.
// Assumes a command parser upstream that hands over decoded commands.
package gsr_pkg;

  // Event status flag positions
  localparam int ESF_OPC_BIT = 0;
  localparam int ESF_QUERY_ERR_BIT = 3;
  localparam int ESF_EXEC_ERR_BIT = 4;
  localparam int ESF_CMD_ERR_BIT = 5;
  localparam int ESF_POWER_ON_BIT = 7;

  // Status byte bit positions
  localparam int SSB_MEAS_BIT = 0;
  localparam int SSB_MSG_AVAIL_BIT = 4;
  localparam int SSB_EVENT_BIT = 5;
  localparam int SSB_MASTER_BIT = 6;

  // Reset values
  localparam logic [7:0] ESF_RESET = 8'h80;
  localparam logic [7:0] EEM_RESET = 8'h00;
  localparam logic [7:0] SRM_RESET = 8'h00;
  localparam logic [7:0] MCM_RESET = 8'h00;

  // Fixed self-test answer
  localparam logic [7:0] SELF_TEST_RESULT = 8'h00;

  // Decoded command codes from the parser
  typedef enum logic [3:0] {
    GSR_CMD_WAIT = 4'h0,
    GSR_CMD_EEM_SET = 4'h1,
    GSR_CMD_EEM_QRY = 4'h2,
    GSR_CMD_OPC_SET = 4'h3,
    GSR_CMD_SRM_SET = 4'h4,
    GSR_CMD_SRM_QRY = 4'h5,
    GSR_CMD_SSB_QRY = 4'h6,
    GSR_CMD_TST_QRY = 4'h7,
    GSR_CMD_MCM_SET = 4'h8,
    GSR_CMD_MCM_QRY = 4'h9,
    GSR_CMD_ESF_QRY = 4'ha
  } gsr_cmd_code_t;

  // One decoded command
  typedef struct packed {
    logic valid;
    logic from_gpib;
    gsr_cmd_code_t code;
    logic [7:0] arg;
  } gsr_cmd_t;

  // Error events reported by the parser and executor
  typedef struct packed {
    logic query_err;
    logic exec_err;
    logic cmd_err;
  } gsr_err_t;

endpackage : gsr_pkg

// [rtl/gsr_event_reg.sv]
// Sticky event status flags with enable-mask summary.
// Assumes set pulses and the clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module gsr_event_reg (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] set_vec_in,
  input wire logic clear_in,
  input wire logic [7:0] enable_mask_in,
  output logic [7:0] flags_out,
  output logic summary_out
);

  logic [7:0] flags_q; // Sticky flags
  logic [7:0] flags_d; // Next flags

  // Clear first, then set, so a same-cycle event survives the read
  always_comb begin
    flags_d = clear_in ? 8'h00 : flags_q;
    flags_d = flags_d | set_vec_in;
  end

  // Reset value carries the power-on flag
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      flags_q <= gsr_pkg::ESF_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_out = flags_q;
  assign summary_out = |(flags_q & enable_mask_in);

endmodule : gsr_event_reg
`default_nettype wire

// [rtl/gsr_srq.sv]
// Status byte assembly and service request generation.
// Assumes summary inputs are on the same clock as this module.
`timescale 1ns/1ps
`default_nettype none
module gsr_srq (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic meas_summary_in,
  input wire logic msg_avail_in,
  input wire logic event_summary_in,
  input wire logic [7:0] srq_mask_in,
  output logic [7:0] status_byte_out,
  output logic srq_out
);

  logic [7:0] ssb_d; // Next status byte
  logic [7:0] ssb_q; // Registered status byte
  logic master_sum; // Master summary of enabled bits

  // Bits other than 0, 4, 5, 6 stay zero
  always_comb begin
    ssb_d = 8'h00;
    ssb_d[gsr_pkg::SSB_MEAS_BIT] = meas_summary_in;
    ssb_d[gsr_pkg::SSB_MSG_AVAIL_BIT] = msg_avail_in;
    ssb_d[gsr_pkg::SSB_EVENT_BIT] = event_summary_in;
    // mask gates request; the summary bit itself is excluded
    master_sum = |(ssb_d & srq_mask_in & ~(8'h01 << gsr_pkg::SSB_MASTER_BIT));
    ssb_d[gsr_pkg::SSB_MASTER_BIT] = master_sum;
  end

  // Register so the byte and request move together
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ssb_q <= 8'h00;
    end else begin
      ssb_q <= ssb_d;
    end
  end

  assign status_byte_out = ssb_q;
  assign srq_out = ssb_q[gsr_pkg::SSB_MASTER_BIT];

endmodule : gsr_srq
`default_nettype wire

// [rtl/gsr_top.sv]
// Status reporting and service request logic for the GPIB remote port.
// Assumes a parser on the same clock that delivers one decoded command
// per cycle at most, and formats returned integers as decimal text.
`timescale 1ns/1ps
`default_nettype none
module gsr_top #(
  parameter int MC_WIDTH = 8 // Measurement condition width
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire gsr_pkg::gsr_cmd_t cmd_in,
  input wire gsr_pkg::gsr_err_t err_in,
  input wire logic [MC_WIDTH-1:0] meas_cond_in,
  input wire logic gpib_enable_in,
  input wire logic resp_ready_in,
  output logic resp_valid_out,
  output logic [7:0] resp_data_out,
  output logic cmd_ack_out,
  output logic cmd_ignored_out,
  output logic srq_out,
  output logic [7:0] status_byte_out,
  output logic [7:0] event_flags_out
);

  // Responses are one byte wide, so wider conditions cannot be read back
  generate
    if (MC_WIDTH < 1 || MC_WIDTH > 8) begin : g_bad_width
      $error("MC_WIDTH must be 1 to 8");
    end
  endgenerate

  // Response holding states
  typedef enum logic [1:0] {
    GSR_RSP_IDLE = 2'b01,
    GSR_RSP_WAIT = 2'b10
  } gsr_rsp_state_t;

  gsr_rsp_state_t rsp_state_q; // Response state
  gsr_rsp_state_t rsp_state_d; // Next response state

  logic [7:0] eem_q; // Event enable mask
  logic [7:0] srm_q; // Service request mask
  logic [MC_WIDTH-1:0] mcm_q; // Measurement condition mask
  logic [7:0] resp_data_q; // Held response value
  logic [7:0] resp_data_d; // Next response value
  logic ack_q; // Accepted pulse
  logic ignored_q; // Ignored pulse
  logic gpib_en_q; // Previous port enable

  logic [7:0] esf_flags; // Event flags from sticky register
  logic esf_summary; // Enabled event summary
  logic [7:0] esf_set; // Event set vector
  logic esf_clear; // Clear after read
  logic meas_summary; // Enabled measurement summary
  logic msg_avail; // A response is waiting

  logic cmd_take; // Command accepted this cycle
  logic cmd_skip; // Command refused this cycle
  logic is_query; // Accepted command is a query
  logic known_cmd; // Code is one we serve
  logic resp_drain; // Host takes the response now
  logic rsp_busy; // Slot still occupied after drain
  logic query_clash; // Query while slot occupied
  logic query_load; // Query loads a new answer
  logic gpib_rise; // Port went disabled to enabled

  // True for the codes that produce an answer
  function automatic logic code_is_query(input gsr_pkg::gsr_cmd_code_t c);
    case (c)
      gsr_pkg::GSR_CMD_EEM_QRY,
      gsr_pkg::GSR_CMD_SRM_QRY,
      gsr_pkg::GSR_CMD_SSB_QRY,
      gsr_pkg::GSR_CMD_TST_QRY,
      gsr_pkg::GSR_CMD_MCM_QRY,
      gsr_pkg::GSR_CMD_ESF_QRY: code_is_query = 1'b1;
      default: code_is_query = 1'b0;
    endcase
  endfunction : code_is_query

  // True for every code that this block serves
  function automatic logic code_is_known(input gsr_pkg::gsr_cmd_code_t c);
    case (c)
      gsr_pkg::GSR_CMD_WAIT,
      gsr_pkg::GSR_CMD_EEM_SET,
      gsr_pkg::GSR_CMD_OPC_SET,
      gsr_pkg::GSR_CMD_SRM_SET,
      gsr_pkg::GSR_CMD_MCM_SET: code_is_known = 1'b1;
      default: code_is_known = code_is_query(c);
    endcase
  endfunction : code_is_known

  // Command gating by source port
  always_comb begin
    cmd_take = cmd_in.valid && cmd_in.from_gpib;
    cmd_skip = cmd_in.valid && !cmd_in.from_gpib;
    known_cmd = code_is_known(cmd_in.code);
    is_query = cmd_take && known_cmd && code_is_query(cmd_in.code);
  end

  // Response slot bookkeeping
  always_comb begin
    msg_avail = (rsp_state_q == GSR_RSP_WAIT);
    resp_drain = msg_avail && resp_ready_in;
    rsp_busy = msg_avail && !resp_drain;
    // A second query while the first is unread is a query error
    query_clash = is_query && rsp_busy;
    query_load = is_query && !rsp_busy;
  end

  // Port enable edge for the power-on flag
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      gpib_en_q <= 1'b0;
    end else begin
      gpib_en_q <= gpib_enable_in;
    end
  end

  // Previous value resets low, so reset already sets the flag itself
  assign gpib_rise = gpib_enable_in && !gpib_en_q;

  // Event flag set sources
  always_comb begin
    esf_set = 8'h00;
    esf_set[gsr_pkg::ESF_OPC_BIT] = cmd_take && known_cmd &&
      (cmd_in.code == gsr_pkg::GSR_CMD_OPC_SET);
    esf_set[gsr_pkg::ESF_QUERY_ERR_BIT] = err_in.query_err || query_clash;
    esf_set[gsr_pkg::ESF_EXEC_ERR_BIT] = err_in.exec_err;
    esf_set[gsr_pkg::ESF_CMD_ERR_BIT] = err_in.cmd_err ||
      (cmd_take && !known_cmd);
    esf_set[gsr_pkg::ESF_POWER_ON_BIT] = gpib_rise;
  end

  assign esf_clear = query_load && (cmd_in.code == gsr_pkg::GSR_CMD_ESF_QRY);

  // Sticky event flags with enable summary
  gsr_event_reg u_event_reg (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .set_vec_in(esf_set),
    .clear_in(esf_clear),
    .enable_mask_in(eem_q),
    .flags_out(esf_flags),
    .summary_out(esf_summary)
  );

  assign meas_summary = |(meas_cond_in & mcm_q);

  // Status byte and service request
  gsr_srq u_srq (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .meas_summary_in(meas_summary),
    .msg_avail_in(msg_avail),
    .event_summary_in(esf_summary),
    .srq_mask_in(srm_q),
    .status_byte_out(status_byte_out),
    .srq_out(srq_out)
  );

  // Event enable mask
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      eem_q <= gsr_pkg::EEM_RESET;
    end else if (cmd_take && cmd_in.code == gsr_pkg::GSR_CMD_EEM_SET) begin
      eem_q <= cmd_in.arg;
    end
  end

  // Service request mask
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      srm_q <= gsr_pkg::SRM_RESET;
    end else if (cmd_take && cmd_in.code == gsr_pkg::GSR_CMD_SRM_SET) begin
      // all bits kept; unused ones gate nothing
      srm_q <= cmd_in.arg;
    end
  end

  // Measurement condition mask
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mcm_q <= gsr_pkg::MCM_RESET[MC_WIDTH-1:0];
    end else if (cmd_take && cmd_in.code == gsr_pkg::GSR_CMD_MCM_SET) begin
      mcm_q <= cmd_in.arg[MC_WIDTH-1:0];
    end
  end

  // Answer value for the accepted query
  always_comb begin
    resp_data_d = resp_data_q;
    if (query_load) begin
      case (cmd_in.code)
        gsr_pkg::GSR_CMD_EEM_QRY: resp_data_d = eem_q;
        gsr_pkg::GSR_CMD_SRM_QRY: resp_data_d = srm_q;
        gsr_pkg::GSR_CMD_SSB_QRY: resp_data_d = status_byte_out;
        gsr_pkg::GSR_CMD_TST_QRY: resp_data_d = gsr_pkg::SELF_TEST_RESULT;
        gsr_pkg::GSR_CMD_MCM_QRY: begin
          resp_data_d = 8'h00;
          resp_data_d[MC_WIDTH-1:0] = mcm_q;
        end
        gsr_pkg::GSR_CMD_ESF_QRY: resp_data_d = esf_flags;
        default: resp_data_d = resp_data_q;
      endcase
    end
  end

  // Response slot state machine
  always_comb begin
    rsp_state_d = rsp_state_q;
    case (rsp_state_q)
      GSR_RSP_IDLE: begin
        if (query_load) begin
          rsp_state_d = GSR_RSP_WAIT;
        end
      end
      GSR_RSP_WAIT: begin
        // A query in the draining cycle refills the slot at once
        if (resp_drain && !query_load) begin
          rsp_state_d = GSR_RSP_IDLE;
        end
      end
      default: rsp_state_d = GSR_RSP_IDLE;
    endcase
  end

  // Response state and data registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rsp_state_q <= GSR_RSP_IDLE;
      resp_data_q <= 8'h00;
    end else begin
      rsp_state_q <= rsp_state_d;
      resp_data_q <= resp_data_d;
    end
  end

  // Accept and ignore pulses for the parser
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      ignored_q <= 1'b0;
    end else begin
      ack_q <= cmd_take && known_cmd && !query_clash;
      ignored_q <= cmd_skip;
    end
  end

  // Output drive; handshake valid follows the slot state
  assign resp_valid_out = msg_avail;
  assign resp_data_out = resp_data_q;
  assign cmd_ack_out = ack_q;
  assign cmd_ignored_out = ignored_q;
  assign event_flags_out = esf_flags;

endmodule : gsr_top
`default_nettype wire

// [sim/gsr_host_model.sv]
// Host bus controller model that reads waiting replies.
// Assumes a reply is taken at the rising edge where ready is high.
`timescale 1ns/1ps
`default_nettype none
module gsr_host_model (
  input wire logic core_clk_in,
  input wire logic resp_valid_in,
  input wire logic [3:0] delay_in,
  output logic resp_ready_out
);
  // Cycles already waited on this reply
  logic [3:0] wait_q = 4'h0;
  initial resp_ready_out = 1'b0;

  // reads waiting reply
  // Drops ready after each read so one reply is never taken twice
  always @(negedge core_clk_in) begin
    if (!resp_valid_in || resp_ready_out) begin
      wait_q <= 4'h0;
      resp_ready_out <= 1'b0;
    end else if (wait_q >= delay_in) begin
      resp_ready_out <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : gsr_host_model
`default_nettype wire

// [sim/gsr_top_asserts.sv]
// Port-level checker for the status-reporting block.
// Assumes it is bound to gsr_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module gsr_top_asserts #(
  parameter int MC_WIDTH = 8 // Measurement condition width
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire gsr_pkg::gsr_cmd_t cmd_in,
  input wire gsr_pkg::gsr_err_t err_in,
  input wire logic [MC_WIDTH-1:0] meas_cond_in,
  input wire logic gpib_enable_in,
  input wire logic resp_ready_in,
  input wire logic resp_valid_out,
  input wire logic [7:0] resp_data_out,
  input wire logic cmd_ack_out,
  input wire logic cmd_ignored_out,
  input wire logic srq_out,
  input wire logic [7:0] status_byte_out,
  input wire logic [7:0] event_flags_out
);
  // Shadow masks, mirrored from accepted set commands
  logic [7:0] eem_q;
  logic [7:0] srm_q;
  // Command arriving from the GPIB port
  wire logic gq = cmd_in.valid && cmd_in.from_gpib;
  // Reply slot free, so a query is loaded
  wire logic fr = !resp_valid_out || resp_ready_in;

  // Event enable shadow
  always_ff @(posedge core_clk_in) begin
    if (rst_in) eem_q <= 8'h00;
    else if (gq && cmd_in.code == gsr_pkg::GSR_CMD_EEM_SET) eem_q <= cmd_in.arg;
  end

  // Request enable shadow
  always_ff @(posedge core_clk_in) begin
    if (rst_in) srm_q <= 8'h00;
    else if (gq && cmd_in.code == gsr_pkg::GSR_CMD_SRM_SET) srm_q <= cmd_in.arg;
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  AST_NON_GPIB_DROP: assert property (
    cmd_in.valid && !cmd_in.from_gpib |=> cmd_ignored_out && !cmd_ack_out)
    else $error("non-gpib command not dropped");
  AST_WAIT_ACK: assert property (
    gq && cmd_in.code == gsr_pkg::GSR_CMD_WAIT |=> cmd_ack_out)
    else $error("wait command not acknowledged");
  AST_ERR_FLAGS: assert property (
    (err_in.query_err |=> event_flags_out[3]) and
    (err_in.exec_err |=> event_flags_out[4]) and
    (err_in.cmd_err |=> event_flags_out[5]))
    else $error("error pulse did not set its flag");
  AST_OPC_SET: assert property (
    gq && cmd_in.code == gsr_pkg::GSR_CMD_OPC_SET |=> event_flags_out[0])
    else $error("operation complete flag not set");
  AST_EEM_QRY: assert property (
    gq && fr && cmd_in.code == gsr_pkg::GSR_CMD_EEM_QRY
    |=> resp_valid_out && resp_data_out == eem_q)
    else $error("event mask reply wrong");
  AST_ESF_QRY: assert property (
    gq && fr && cmd_in.code == gsr_pkg::GSR_CMD_ESF_QRY
    |=> resp_data_out == $past(event_flags_out))
    else $error("event flag reply wrong");
  AST_RESP_HOLD: assert property (
    resp_valid_out && !resp_ready_in
    |=> resp_valid_out && $stable(resp_data_out))
    else $error("unread reply lost");
  AST_MSG_BIT: assert property (
    status_byte_out[4] == $past(resp_valid_out))
    else $error("message bit does not follow reply");
  AST_EVT_SUM: assert property (
    status_byte_out[5] == |($past(event_flags_out) & $past(eem_q)))
    else $error("event summary bit wrong");
  // Summary bit rebuilt from the byte and last cycle's request mask
  AST_MSS_SRQ: assert property (
    status_byte_out[6] == |(status_byte_out & $past(srm_q) & 8'hbf))
    else $error("summary bit does not match masked byte");
  AST_SRQ_ON: assert property (
    (|(status_byte_out & srm_q & 8'hbf))[*2] |-> srq_out)
    else $error("enabled status bit gave no request");
  AST_GPIB_EN: assert property (
    $rose(gpib_enable_in) |-> ##[1:2] event_flags_out[7])
    else $error("port enable did not set power flag");
endmodule : gsr_top_asserts

bind gsr_top gsr_top_asserts #(.MC_WIDTH(MC_WIDTH)) u_chk (
  .core_clk_in(core_clk_in),
  .rst_in(rst_in),
  .cmd_in(cmd_in),
  .err_in(err_in),
  .meas_cond_in(meas_cond_in),
  .gpib_enable_in(gpib_enable_in),
  .resp_ready_in(resp_ready_in),
  .resp_valid_out(resp_valid_out),
  .resp_data_out(resp_data_out),
  .cmd_ack_out(cmd_ack_out),
  .cmd_ignored_out(cmd_ignored_out),
  .srq_out(srq_out),
  .status_byte_out(status_byte_out),
  .event_flags_out(event_flags_out)
);
`default_nettype wire

// [sim/gsr_top_bench.sv]
// Self-checking bench for the status-reporting block.
// Assumes the host model reads replies; replies are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module gsr_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  gsr_pkg::gsr_cmd_t cmd = '0;
  gsr_pkg::gsr_err_t err = '0;
  logic [7:0] mc = 8'h00; // Measurement conditions
  logic en = 1'b1; // Port enable
  logic [3:0] dly = 4'h0; // Host read delay
  logic rdy, rv, ack, ign, srq;
  logic [7:0] rd, sb, ef, r;
  logic [7:0] q[$]; // Expected replies, oldest first
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  gsr_pkg::gsr_cmd_code_t st[3] = '{gsr_pkg::GSR_CMD_EEM_SET,
    gsr_pkg::GSR_CMD_SRM_SET, gsr_pkg::GSR_CMD_MCM_SET};
  gsr_pkg::gsr_cmd_code_t qs[3] = '{gsr_pkg::GSR_CMD_EEM_QRY,
    gsr_pkg::GSR_CMD_SRM_QRY, gsr_pkg::GSR_CMD_MCM_QRY};

  always #12.5 clk = ~clk;

  gsr_top #(.MC_WIDTH(8)) dut (.core_clk_in(clk), .rst_in(rst),
    .cmd_in(cmd), .err_in(err), .meas_cond_in(mc), .gpib_enable_in(en),
    .resp_ready_in(rdy), .resp_valid_out(rv), .resp_data_out(rd),
    .cmd_ack_out(ack), .cmd_ignored_out(ign), .srq_out(srq),
    .status_byte_out(sb), .event_flags_out(ef));
  gsr_host_model host (.core_clk_in(clk), .resp_valid_in(rv),
    .delay_in(dly), .resp_ready_out(rdy));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic test_done();
    // A noted reply that never came counts against the run
    miscompares += q.size();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // Command held until idle or the next send replaces it
  task automatic send(input gsr_pkg::gsr_cmd_code_t c, input logic [7:0] a,
    input logic g);
    @(negedge clk);
    cmd <= {1'b1, g, c, a};
  endtask : send

  task automatic idle();
    @(negedge clk);
    cmd.valid <= 1'b0;
  endtask : idle

  // Ends where the acknowledge pulse can be seen
  task automatic go(input gsr_pkg::gsr_cmd_code_t c, input logic [7:0] a,
    input logic g);
    send(c, a, g);
    idle();
  endtask : go

  // Waits, bounded, until every noted reply was read
  task automatic drain();
    for (int n = 0; n < 40 && q.size() > 0; n++) @(negedge clk);
    @(negedge clk);
  endtask : drain

  task automatic qry(input gsr_pkg::gsr_cmd_code_t c, input logic [7:0] e);
    q.push_back(e);
    go(c, 8'h00, 1'b1);
    drain();
  endtask : qry

  // Reply watcher: each read reply against the oldest note
  always @(posedge clk) begin
    if (!rst && rv && rdy) begin
      if (q.size() > 0) begin
        chk(rd, q.pop_front());
      end else begin
        $display("unexpected at %0t: got %h want none", $time, rd);
        miscompares++;
      end
    end
  end

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    void'($urandom(28));
    repeat (3) @(negedge clk);
    rst <= 1'b0;
    chk(ef, 8'h80);
    chk(sb, 8'h00);
    qry(gsr_pkg::GSR_CMD_ESF_QRY, 8'h80);
    chk(ef, 8'h00);
    $display("test reset done");
    // Each mask with zero, all ones and a random value
    for (int i = 0; i < 9; i++) begin
      r = (i < 3) ? 8'h00 : (i < 6) ? 8'hff : 8'($urandom);
      go(st[i % 3], r, 1'b1);
      chk(8'(ack), 8'h01);
      qry(qs[i % 3], r);
    end
    qry(gsr_pkg::GSR_CMD_TST_QRY, 8'h00);
    go(gsr_pkg::GSR_CMD_WAIT, 8'h00, 1'b1);
    chk(8'(ack), 8'h01);
    chk(ef, 8'h00);
    $display("test masks done");
    go(gsr_pkg::GSR_CMD_OPC_SET, 8'h00, 1'b0);
    chk(8'(ign), 8'h01);
    go(gsr_pkg::GSR_CMD_EEM_SET, 8'h21, 1'b1);
    go(gsr_pkg::GSR_CMD_SRM_SET, 8'h20, 1'b1);
    chk(ef, 8'h00);
    go(gsr_pkg::GSR_CMD_OPC_SET, 8'h00, 1'b1);
    repeat (2) @(negedge clk);
    chk(sb, 8'h60);
    chk(8'(srq), 8'h01);
    qry(gsr_pkg::GSR_CMD_SSB_QRY, 8'h60);
    err <= '1;
    @(negedge clk);
    err <= '0;
    qry(gsr_pkg::GSR_CMD_ESF_QRY, 8'h39);
    repeat (3) @(negedge clk);
    chk(sb, 8'h00);
    chk(8'(srq), 8'h00);
    $display("test events done");
    go(gsr_pkg::GSR_CMD_MCM_SET, 8'h05, 1'b1);
    go(gsr_pkg::GSR_CMD_SRM_SET, 8'h01, 1'b1);
    r = 8'($urandom) & 8'hfa;
    mc <= r | 8'h04;
    repeat (4) @(negedge clk);
    chk(sb, 8'h41);
    mc <= r;
    repeat (4) @(negedge clk);
    chk(sb, 8'h00);
    $display("test conditions done");
    // Slow host; second query lands on an unread reply
    dly <= 4'h4;
    go(gsr_pkg::GSR_CMD_SRM_SET, 8'h10, 1'b1);
    q.push_back(8'h21);
    send(gsr_pkg::GSR_CMD_EEM_QRY, 8'h00, 1'b1);
    send(gsr_pkg::GSR_CMD_EEM_QRY, 8'h00, 1'b1);
    idle();
    chk(sb & 8'h10, 8'h10);
    @(negedge clk);
    chk(8'(srq), 8'h01);
    drain();
    qry(gsr_pkg::GSR_CMD_ESF_QRY, 8'h08);
    // Unserved code: no acknowledge, command error flag
    go(gsr_pkg::gsr_cmd_code_t'(4'hb), 8'h00, 1'b1);
    chk(8'(ack), 8'h00);
    qry(gsr_pkg::GSR_CMD_ESF_QRY, 8'h20);
    $display("test refused query done");
    en <= 1'b0;
    repeat (2) @(negedge clk);
    en <= 1'b1;
    repeat (3) @(negedge clk);
    chk(ef, 8'h80);
    $display("test port enable done");
    test_done();
  end
endmodule : gsr_top_bench
`default_nettype wire
